// [hw/autoneg_np_pkg.sv]
// constants for the auto-negotiation expansion and next-page register bank
// assumes a 16-bit register view placed in the low bits of a 32-bit wishbone word
`default_nettype none
package autoneg_np_pkg;
    localparam int REG_W = 16;
    localparam int ADDR_W = 8;
    // register indices; byte address is four times the index
    localparam logic [ADDR_W-1:0] IDX_EXP_STATUS = 8'h06;
    localparam logic [ADDR_W-1:0] IDX_NP_TX = 8'h07;
    localparam logic [ADDR_W-1:0] IDX_NP_RX = 8'h08;
    // expansion status fields
    localparam int EXP_LOC_VALID = 6;
    localparam int EXP_LOC_SEL = 5;
    localparam int EXP_PDF = 4;
    localparam int EXP_LP_NP = 3;
    localparam int EXP_LOC_NP = 2;
    localparam int EXP_PAGE_RX = 1;
    localparam int EXP_LP_AN = 0;
    // next-page fields
    localparam int NP_MORE = 15;
    localparam int NP_ACK = 14;
    localparam int NP_MSG = 13;
    localparam int NP_COMPLY = 12;
    localparam int NP_TOGGLE = 11;
    localparam int CODE_W = 11;
    localparam logic [CODE_W-1:0] CODE_NULL = 11'h001;
    localparam logic [REG_W-1:0] NP_RESET = 16'h2001;
    // software-writable bits of the transmit page
    localparam logic [REG_W-1:0] NP_TX_WMASK = 16'hB7FF;
endpackage
`default_nettype wire

// [hw/wb_word_reg.sv]
// one register with byte enables and a mask of writable bits
// assumes write strobe is a single cycle, same clock
`default_nettype none
module wb_word_reg #(
    parameter int W = 16,
    parameter logic [W-1:0] RST = '0,
    parameter logic [W-1:0] WMASK = '1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic we_i,
    input wire logic [1:0] sel_i,
    input wire logic [W-1:0] wdat_i,
    input wire logic [W-1:0] hw_mask_i,
    input wire logic [W-1:0] hw_val_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] lane_m;
    logic [W-1:0] sw_m;
    logic [W-1:0] d;
    assign lane_m = {{(W/2){sel_i[1]}}, {(W/2){sel_i[0]}}};
    assign sw_m = we_i ? (lane_m & WMASK) : '0;
    // hardware updates outrank software on the same bit
    assign d = (hw_val_i & hw_mask_i) | (wdat_i & sw_m & ~hw_mask_i) | (q_o & ~sw_m & ~hw_mask_i);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_o <= RST;
        end else begin
            q_o <= d;
        end
    end
endmodule
`default_nettype wire

// [hw/autoneg_next_page_regs.sv]
// expansion status, next-page transmit and next-page receive registers
// assumes the negotiation engine drives status inputs on clk_i; page strobe is one cycle
`default_nettype none
module autoneg_next_page_regs
    import autoneg_np_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W+1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic parallel_detect_fault_i,
    input wire logic partner_next_page_capable_i,
    input wire logic partner_autoneg_capable_i,
    input wire logic local_ack_i,
    input wire logic page_rx_strobe_i,
    input wire logic [REG_W-1:0] page_rx_word_i,
    output logic [REG_W-1:0] tx_page_o
);
    //////////////////////////////////////////////////////////////////////
    logic ack_q;
    logic page_rx_q;
    logic toggle_q;
    logic [REG_W-1:0] rx_q;
    logic [REG_W-1:0] rd_data_q;
    wire logic req = wb_cyc_i & wb_stb_i & ~ack_q;
    wire logic [ADDR_W-1:0] idx = wb_adr_i[ADDR_W+1:2];
    wire logic hit_exp = idx == IDX_EXP_STATUS;
    wire logic hit_tx = idx == IDX_NP_TX;
    wire logic hit_rx = idx == IDX_NP_RX;
    wire logic wr_tx = req & wb_we_i & hit_tx;
    wire logic rd_exp = req & ~wb_we_i & hit_exp;
    wire logic [REG_W-1:0] exp_word;
    wire logic [REG_W-1:0] tx_q;
    wire logic [REG_W-1:0] rd_mux;
    wire logic [REG_W-1:0] tx_hw_mask;
    wire logic [REG_W-1:0] tx_hw_val;

    //////////////////////////////////////////////////////////////////////
    // reserved upper bits always zero
    assign exp_word = {9'h000, 1'b1, 1'b1, parallel_detect_fault_i, partner_next_page_capable_i,
                       1'b1, page_rx_q, partner_autoneg_capable_i};

    //////////////////////////////////////////////////////////////////////
    // hardware owns ack and toggle bits
    assign tx_hw_mask = (16'h0001 << NP_ACK) | (16'h0001 << NP_TOGGLE);
    assign tx_hw_val = ({15'h0000, local_ack_i} << NP_ACK) | ({15'h0000, toggle_q} << NP_TOGGLE);

    // writable transmit fields with reset values
    wb_word_reg #(
        .W(REG_W),
        .RST(NP_RESET),
        .WMASK(NP_TX_WMASK)
    ) u_tx_reg (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .we_i(wr_tx),
        .sel_i(wb_sel_i[1:0]),
        .wdat_i(wb_dat_i[REG_W-1:0]),
        .hw_mask_i(tx_hw_mask),
        .hw_val_i(tx_hw_val),
        .q_o(tx_q)
    );
    assign tx_page_o = tx_q;

    //////////////////////////////////////////////////////////////////////
    // set wins over clear-on-read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            page_rx_q <= 1'b0;
        end else if (page_rx_strobe_i) begin
            page_rx_q <= 1'b1;
        end else if (rd_exp) begin
            page_rx_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            toggle_q <= 1'b0;
        end else if (page_rx_strobe_i) begin
            toggle_q <= ~page_rx_word_i[NP_TOGGLE];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_q <= NP_RESET;
        end else if (page_rx_strobe_i) begin
            rx_q <= page_rx_word_i;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // unmapped addresses read zero and still acknowledge, so a stray access never hangs
    assign rd_mux = hit_exp ? exp_word : hit_tx ? tx_q : hit_rx ? rx_q : 16'h0000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rd_data_q <= 16'h0000;
        end else begin
            ack_q <= req;
            if (req) begin
                rd_data_q <= rd_mux;
            end
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = {16'h0000, rd_data_q};

    //////////////////////////////////////////////////////////////////////
    reserved_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_q && $past(hit_exp) && !$past(wb_we_i) |-> wb_dat_o[15:7] == 9'h000)
        else $error("reserved status bits not zero");
    const_ones_a: assert property (@(posedge clk_i) disable iff (rst_i)
        exp_word[EXP_LOC_VALID] && exp_word[EXP_LOC_SEL] && exp_word[EXP_LOC_NP])
        else $error("constant status bits not one");
    page_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_exp && !page_rx_strobe_i |=> !page_rx_q)
        else $error("page flag not cleared by read");
    page_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        page_rx_strobe_i |=> page_rx_q ##1 (page_rx_q || $past(rd_exp)))
        else $error("page flag lost");
    read_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_exp && page_rx_q |=> wb_ack_o && wb_dat_o[EXP_PAGE_RX])
        else $error("page flag not returned on read");
    toggle_inv_a: assert property (@(posedge clk_i) disable iff (rst_i)
        page_rx_strobe_i |=> ##1 tx_q[NP_TOGGLE] == !rx_q[NP_TOGGLE])
        else $error("toggle not inverted");
    rx_capture_a: assert property (@(posedge clk_i) disable iff (rst_i)
        page_rx_strobe_i |=> rx_q == $past(page_rx_word_i) && page_rx_q)
        else $error("receive page not captured with flag");
    tx_ack_ro_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 tx_q[NP_ACK] == $past(local_ack_i))
        else $error("ack bit not hardware driven");
    ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
    req_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
        req |=> wb_ack_o)
        else $error("request not acknowledged next cycle");
    // read data must carry the status levels seen at the taken edge
    fault_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_q && $past(hit_exp) && !$past(wb_we_i) |-> wb_dat_o[EXP_PDF] == $past(parallel_detect_fault_i))
        else $error("fault bit not returned on read");
    lp_np_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_q && $past(hit_exp) && !$past(wb_we_i) |-> wb_dat_o[EXP_LP_NP] == $past(partner_next_page_capable_i))
        else $error("partner next-page bit not returned on read");
    lp_an_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_q && $past(hit_exp) && !$past(wb_we_i) |-> wb_dat_o[EXP_LP_AN] == $past(partner_autoneg_capable_i))
        else $error("partner autoneg bit not returned on read");
    more_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_tx && wb_sel_i[1] |=> tx_q[NP_MORE] == $past(wb_dat_i[NP_MORE]))
        else $error("more-pages bit not written");
    msg_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_tx && wb_sel_i[1] |=> tx_q[NP_MSG] == $past(wb_dat_i[NP_MSG]))
        else $error("message-page bit not written");
    comply_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_tx && wb_sel_i[1] |=> tx_q[NP_COMPLY] == $past(wb_dat_i[NP_COMPLY]))
        else $error("comply bit not written");
    code_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_tx && wb_sel_i[0] |=> tx_q[7:0] == $past(wb_dat_i[7:0]))
        else $error("code low byte not written");
    toggle_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !page_rx_strobe_i |=> $stable(toggle_q))
        else $error("toggle moved without a page");
    rx_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !page_rx_strobe_i |=> $stable(rx_q))
        else $error("receive page moved without a strobe");
endmodule
`default_nettype wire

// [verification/remote_phy_model.sv]
// remote link-partner model: delivers next pages and status levels
// assumes the bench calls its tasks from the clk_i domain
`default_nettype none
module remote_phy_model (
    input wire logic clk_i,
    output logic page_rx_strobe_o,
    output logic [15:0] page_rx_word_o,
    output logic [2:0] status_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        page_rx_strobe_o = 1'b0;
        page_rx_word_o = 16'h0000;
        status_o = 3'h0;
    end
    // word is only valid with the strobe, so it is scrambled afterwards
    task automatic send(input logic [15:0] w);
        @(posedge clk_i);
        page_rx_strobe_o <= 1'b1;
        page_rx_word_o <= w;
        @(posedge clk_i);
        page_rx_strobe_o <= 1'b0;
        page_rx_word_o <= ~w;
    endtask
    task automatic stat(input logic [2:0] s);
        @(posedge clk_i);
        status_o <= s;
    endtask
endmodule
`default_nettype wire

// [verification/test_autoneg_next_page_regs.sv]
// bench for the next-page register bank
// assumes the partner model drives page and status inputs
`default_nettype none
module test_autoneg_next_page_regs;
    import autoneg_np_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [9:0] adr = 10'h000;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic lack = 1'b0;
    logic strobe;
    logic [15:0] word;
    logic [2:0] st;
    logic [15:0] txp;
    logic [15:0] q;
    logic [15:0] qh;
    logic [3:0] sel = 4'hF;
    int failures = 0;
    int checks_done = 0;
    always #2 clk_i = ~clk_i;
    autoneg_next_page_regs u_autoneg_next_page_regs (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .parallel_detect_fault_i(st[2]),
        .partner_next_page_capable_i(st[1]), .partner_autoneg_capable_i(st[0]),
        .local_ack_i(lack), .page_rx_strobe_i(strobe), .page_rx_word_i(word), .tx_page_o(txp));
    remote_phy_model u_remote_phy_model (.clk_i(clk_i), .page_rx_strobe_o(strobe),
        .page_rx_word_o(word), .status_o(st));
    ////////////////////////////////////////////////////////////////
    task automatic results;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] idx, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= {16'h0000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat[15:0];
        qh = rdat[31:16];
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) begin
            failures++;
            $display("[FAIL] %0t no ack", $time);
            results();
        end
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic test_reset;
        wb(1'b0, IDX_EXP_STATUS, 16'h0); chk(q, 16'h0064);
        chk(qh, 16'h0000);
        wb(1'b0, IDX_NP_TX, 16'h0); chk(q, 16'h2001);
        chk(txp, 16'h2001);
        wb(1'b0, IDX_NP_RX, 16'h0); chk(q, 16'h2001);
        $display("test_reset done");
    endtask
    task automatic test_status;
        u_remote_phy_model.stat(3'b111);
        wb(1'b1, IDX_EXP_STATUS, 16'hFFFF);
        wb(1'b0, IDX_EXP_STATUS, 16'h0); chk(q, 16'h007D);
        u_remote_phy_model.stat(3'b000);
        wb(1'b0, IDX_EXP_STATUS, 16'h0); chk(q, 16'h0064);
        $display("test_status done");
    endtask
    task automatic test_pages;
        u_remote_phy_model.send(16'hF8AB);
        wb(1'b0, IDX_EXP_STATUS, 16'h0); chk(q, 16'h0066);
        wb(1'b0, IDX_EXP_STATUS, 16'h0); chk(q, 16'h0064);
        wb(1'b0, IDX_NP_RX, 16'h0); chk(q, 16'hF8AB);
        wb(1'b0, IDX_NP_TX, 16'h0); chk(q, 16'h2001);
        u_remote_phy_model.send(16'h0155);
        wb(1'b0, IDX_NP_RX, 16'h0); chk(q, 16'h0155);
        wb(1'b0, IDX_NP_TX, 16'h0); chk(q, 16'h2801);
        $display("test_pages done");
    endtask
    task automatic test_tx_write;
        wb(1'b1, IDX_NP_TX, 16'hFFFF);
        wb(1'b0, IDX_NP_TX, 16'h0); chk(q, 16'hBFFF);
        lack <= 1'b1;
        wb(1'b1, IDX_NP_TX, 16'h0000);
        wb(1'b0, IDX_NP_TX, 16'h0); chk(q, 16'h4800);
        chk(txp, 16'h4800);
        wb(1'b1, IDX_NP_RX, 16'h0000);
        wb(1'b0, IDX_NP_RX, 16'h0); chk(q, 16'h0155);
        wb(1'b0, 8'h10, 16'h0); chk(q, 16'h0000);
        $display("test_tx_write done");
    endtask
    task automatic test_byte_lanes;
        wb(1'b1, IDX_NP_TX, 16'hFFFF);
        sel <= 4'h1;
        wb(1'b1, IDX_NP_TX, 16'h0000);
        sel <= 4'hF;
        wb(1'b0, IDX_NP_TX, 16'h0); chk(q, 16'hFF00);
        sel <= 4'h2;
        wb(1'b1, IDX_NP_TX, 16'h0000);
        sel <= 4'hF;
        wb(1'b0, IDX_NP_TX, 16'h0); chk(q, 16'h4800);
        $display("test_byte_lanes done");
    endtask
    task automatic test_mid_reset;
        lack <= 1'b0;
        u_remote_phy_model.send(16'hFFFF);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, IDX_EXP_STATUS, 16'h0); chk(q, 16'h0064);
        wb(1'b0, IDX_NP_TX, 16'h0); chk(q, 16'h2001);
        wb(1'b0, IDX_NP_RX, 16'h0); chk(q, 16'h2001);
        $display("test_mid_reset done");
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        test_reset();
        test_status();
        test_pages();
        test_tx_write();
        test_byte_lanes();
        test_mid_reset();
        results();
    end
endmodule
`default_nettype wire
